// file: verilog/sts_frame_map.svh
`ifndef STS_FRAME_MAP_SVH
`define STS_FRAME_MAP_SVH

// framing byte patterns, first received bit in the msb
`define FRAME_A1_BYTE       8'hF6
`define FRAME_A2_BYTE       8'h28
// number of each framing byte that the search looks for
`define FRAME_A1_COUNT      3
`define FRAME_A2_COUNT      3
// bits in a demultiplexed byte
`define BITS_PER_BYTE       8
// last bit index inside a byte
`define LAST_BIT_INDEX      3'h7
// bit index below which the byte clock is high
`define BYTE_CLK_HIGH_BITS  3'h4
// byte periods from the A1 to A2 change on the outputs to frame pulse
`define FRAME_PULSE_DELAY   2'h2
// byte slot of the output tap inside the search window (bytes back)
`define OUTPUT_TAP_BYTE     2

`endif

// file: verilog/sts_frame_pkg.sv
package sts_frame_pkg;

    // search state of the aligner
    typedef enum logic [1:0]
    {
        ALIGN_FREE,
        ALIGN_SEARCH,
        ALIGN_LOCKED
    } align_state_t;

endpackage

// file: verilog/line_sampler.sv
`timescale 1ns/1ps

module line_sampler
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // asynchronous line pins
    input  wire logic line_clock_in,
    input  wire logic line_data_in,
    // one received bit
    output logic      bit_strobe,
    output logic      bit_value
);

    logic clk_s1_q;
    logic clk_s2_q;
    logic clk_s3_q;
    logic dat_s1_q;
    logic dat_s2_q;

    // two-flop synchronisers; data and line clock see the same delay
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            dat_s1_q <= 1'b0;
            dat_s2_q <= 1'b0;
        end
        else
        begin
            clk_s1_q <= line_clock_in;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            dat_s1_q <= line_data_in;
            dat_s2_q <= dat_s1_q;
        end
    end

    // rising edge of the line clock takes the data bit
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bit_strobe <= 1'b0;
            bit_value  <= 1'b0;
        end
        else
        begin
            bit_strobe <= clk_s2_q & ~clk_s3_q;
            bit_value  <= dat_s2_q;
        end
    end

endmodule

// file: verilog/frame_word_detector.sv
`timescale 1ns/1ps
`include "sts_frame_map.svh"

module frame_word_detector
#(
    parameter int A1_COUNT = `FRAME_A1_COUNT,
    parameter int A2_COUNT = `FRAME_A2_COUNT
)
(
    // clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    // received bits
    input  wire logic                                 bit_strobe,
    input  wire logic                                 bit_value,
    // window of the latest bits, newest in bit 0
    output logic [(A1_COUNT+A2_COUNT)*`BITS_PER_BYTE-1:0] window,
    output logic                                      pattern_hit
);

    localparam int NBYTES = A1_COUNT + A2_COUNT;
    localparam int WBITS  = NBYTES * `BITS_PER_BYTE;

    logic [WBITS-1:0] pattern;

    // reference: A1 bytes (oldest) then A2 bytes (newest)
    genvar gi;
    generate
        for (gi = 0; gi < NBYTES; gi = gi + 1)
        begin : g_ref
            assign pattern[gi*`BITS_PER_BYTE +: `BITS_PER_BYTE] =
                (gi < A2_COUNT) ? `FRAME_A2_BYTE : `FRAME_A1_BYTE;
        end
    endgenerate

    // serial shift register, one step per received bit
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            window <= '0;
        else if (bit_strobe)
            window <= {window[WBITS-2:0], bit_value};
    end

    // compared after every bit, so each bit offset is tried
    assign pattern_hit = (window == pattern);

endmodule

// file: verilog/sts_frame_byte_aligner.sv
// Contract
// - framing byte A1 is 11110110, A2 is 00101000 on the serial line.
// - a falling edge on the out-of-frame request arms the frame search.
// - armed search looks for three A1 bytes followed by three A2 bytes.
// - byte clock and data invalid from request fall until the A1-A2 change.
// - byte boundary set by retiming the bit counter at the pattern.
// - detecting the framing sequence is reported by a frame pulse.
// - frame pulse rises 2 byte periods after A1-A2 change on the outputs.
// - frame pulse stays high for exactly one byte period.
// - after a hit the search is disarmed, so payload cannot realign.
// - while aligned and re-armed, one frame pulse per received frame; the block gives one pulse per arming, then disarms.
// - recovery works for line rates from STS-3 up to STS-24.
// - serial line is demultiplexed 1:8 into bytes with a byte clock.
// - first received bit lands on output bit 7, last on bit 0.
// - byte clock runs at one eighth of the line clock.
`timescale 1ns/1ps
`include "sts_frame_map.svh"

module sts_frame_byte_aligner
#(
    parameter int A1_COUNT = `FRAME_A1_COUNT,
    parameter int A2_COUNT = `FRAME_A2_COUNT
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // serial line from the receiver
    input  wire logic       line_clock_in,
    input  wire logic       line_data_in,
    // framer side control
    input  wire logic       out_of_frame_request_n,
    // parallel side
    output logic            byte_clock_out,
    output logic [7:0]      parallel_byte_out,
    output logic            byte_valid,
    output logic            frame_pulse
);

    localparam int NBYTES = A1_COUNT + A2_COUNT;
    localparam int WBITS  = NBYTES * `BITS_PER_BYTE;

    // received bit stream
    logic             bit_strobe;
    logic             bit_value;
    logic [WBITS-1:0] window;
    logic             pattern_hit;

    // request synchroniser and edge
    logic oof_s1_q;
    logic oof_s2_q;
    logic oof_s3_q;
    logic oof_fall;

    // timing generator and state
    sts_frame_pkg::align_state_t state_q;
    logic [2:0]                  bit_cnt_q;
    logic [2:0]                  bit_cnt_d;
    logic                        byte_done;
    logic                        lock_hit;
    logic [1:0]                  fp_cnt_q;

    // serial sampling of the line pins, rate free
    line_sampler u_sampler
    (
        .clk           (clk),
        .reset_n       (reset_n),
        .line_clock_in (line_clock_in),
        .line_data_in  (line_data_in),
        .bit_strobe    (bit_strobe),
        .bit_value     (bit_value)
    );

    // sliding window compared at every bit
    frame_word_detector
    #(
        .A1_COUNT (A1_COUNT),
        .A2_COUNT (A2_COUNT)
    )
    u_detect
    (
        .clk         (clk),
        .reset_n     (reset_n),
        .bit_strobe  (bit_strobe),
        .bit_value   (bit_value),
        .window      (window),
        .pattern_hit (pattern_hit)
    );

    // request pin synchroniser; the second and third stages are compared for the edge
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            oof_s1_q <= 1'b1;
            oof_s2_q <= 1'b1;
            oof_s3_q <= 1'b1;
        end
        else
        begin
            oof_s1_q <= out_of_frame_request_n;
            oof_s2_q <= oof_s1_q;
            oof_s3_q <= oof_s2_q;
        end
    end

    // high-to-low transition of the request
    assign oof_fall = oof_s3_q & ~oof_s2_q;

    // hit counts only while armed and on a fresh bit
    assign lock_hit = (state_q == sts_frame_pkg::ALIGN_SEARCH)
                    & bit_strobe & pattern_hit & ~oof_fall;

    // byte boundary: the eighth bit of a byte has arrived
    assign byte_done = bit_strobe & (bit_cnt_q == `LAST_BIT_INDEX);

    // next bit index; a hit puts the boundary on the current bit
    always_comb
    begin
        bit_cnt_d = bit_cnt_q;
        if (lock_hit)
            bit_cnt_d = 3'h0;
        else if (bit_strobe)
            bit_cnt_d = (bit_cnt_q == `LAST_BIT_INDEX) ? 3'h0
                                                       : bit_cnt_q + 3'h1;
    end

    // alignment state: request arms, hit locks and disarms
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            state_q <= sts_frame_pkg::ALIGN_FREE;
        else if (oof_fall)
            state_q <= sts_frame_pkg::ALIGN_SEARCH;
        else
        begin
            case (state_q)
                sts_frame_pkg::ALIGN_SEARCH:
                    if (lock_hit)
                        state_q <= sts_frame_pkg::ALIGN_LOCKED;
                default:
                    state_q <= state_q;
            endcase
        end
    end

    // bit counter is the timing generator of the 1:8 conversion
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            bit_cnt_q <= 3'h0;
        else
            bit_cnt_q <= bit_cnt_d;
    end

    // byte clock: high for the first half of each byte, eighth rate
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            byte_clock_out <= 1'b0;
        else if (oof_fall || state_q == sts_frame_pkg::ALIGN_SEARCH)
            byte_clock_out <= lock_hit;
        else if (bit_strobe)
            byte_clock_out <= (bit_cnt_d < `BYTE_CLK_HIGH_BITS);
    end

    // parallel byte, two bytes behind the newest, first bit in bit 7
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            parallel_byte_out <= 8'h00;
        else if (lock_hit ||
                 (byte_done && state_q != sts_frame_pkg::ALIGN_SEARCH))
            parallel_byte_out <=
                window[`OUTPUT_TAP_BYTE*`BITS_PER_BYTE +: `BITS_PER_BYTE];
    end

    // validity: dropped by the request, restored at the first A2 byte
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            byte_valid <= 1'b0;
        else if (oof_fall)
            byte_valid <= 1'b0;
        else if (lock_hit)
            byte_valid <= 1'b1;
    end

    // frame pulse delay in byte periods after the first A2 is shown
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            fp_cnt_q <= 2'h0;
        else if (oof_fall)
            fp_cnt_q <= 2'h0;
        else if (lock_hit)
            fp_cnt_q <= `FRAME_PULSE_DELAY;
        else if (byte_done && fp_cnt_q != 2'h0)
            fp_cnt_q <= fp_cnt_q - 2'h1;
    end

    // one byte period wide frame pulse per detected frame
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            frame_pulse <= 1'b0;
        else if (oof_fall)
            frame_pulse <= 1'b0;
        else if (byte_done)
            frame_pulse <= (fp_cnt_q == 2'h1);
    end

endmodule

// file: verif/frame_align_chk.sv
`timescale 1ns/1ps
`include "sts_frame_map.svh"

module frame_align_chk
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // line and request inputs
    input  wire logic       line_clock_in,
    input  wire logic       line_data_in,
    input  wire logic       out_of_frame_request_n,
    // parallel side
    input  wire logic       byte_clock_out,
    input  wire logic [7:0] parallel_byte_out,
    input  wire logic       byte_valid,
    input  wire logic       frame_pulse
);
    logic [3:0] edges_q;
    logic [1:0] bytes_q;
    logic       pulsed_q;

    // line edges per byte, byte clocks since lock, pulse seen since arming
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            edges_q  <= 4'h0;
            bytes_q  <= 2'h0;
            pulsed_q <= 1'b0;
        end
        else
        begin
            if ($rose(byte_clock_out))
                edges_q <= {3'h0, $rose(line_clock_in)};
            else if ($rose(line_clock_in))
                edges_q <= edges_q + 4'h1;
            if ($rose(byte_valid))
                bytes_q <= 2'h1;
            else if ($rose(byte_clock_out) && bytes_q != 2'h3)
                bytes_q <= bytes_q + 2'h1;
            if ($fell(out_of_frame_request_n))
                pulsed_q <= 1'b0;
            else if (frame_pulse)
                pulsed_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    valid_drop_a: assert property (
        $fell(out_of_frame_request_n) |-> ##[1:5] !byte_valid)
        else $error("byte valid kept after request");
    lock_byte_a: assert property (
        $rose(byte_valid) |-> byte_clock_out
        && parallel_byte_out == `FRAME_A2_BYTE)
        else $error("lock byte wrong");
    pulse_delay_a: assert property (
        $rose(frame_pulse) |-> bytes_q == 2'h2 && $rose(byte_clock_out))
        else $error("frame pulse misplaced");
    pulse_once_a: assert property (
        $rose(frame_pulse) |-> !pulsed_q)
        else $error("second pulse without arming");
    pulse_hold_a: assert property (
        frame_pulse && !$rose(frame_pulse) |-> !$rose(byte_clock_out))
        else $error("frame pulse too long");
    pulse_end_a: assert property (
        $fell(frame_pulse) |-> $rose(byte_clock_out))
        else $error("frame pulse ended early");
    byte_ratio_a: assert property (
        $rose(byte_clock_out) && $past(byte_valid) |-> edges_q == 4'h8)
        else $error("byte clock not line over 8");
    data_steady_a: assert property (
        byte_valid && $changed(parallel_byte_out) |-> $rose(byte_clock_out))
        else $error("data moved off boundary");
endmodule

bind sts_frame_byte_aligner frame_align_chk u_chk
(
    .clk, .reset_n, .line_clock_in, .line_data_in, .out_of_frame_request_n,
    .byte_clock_out, .parallel_byte_out, .byte_valid, .frame_pulse
);

// file: verif/line_source.sv
`timescale 1ns/1ps

module line_source
(
    // serial line toward the block
    output logic line_clock_in,
    output logic line_data_in
);
    logic bits_q [$];

    // queue the n leading bits of v, first sent from the msb
    task automatic push_bits(input logic [7:0] v, input int n);
        for (int i = 0; i < n; i++)
            bits_q.push_back(v[7 - i]);
    endtask

    // 160 ns bits, data moves while the clock is low; idle clock stands
    initial
    begin
        line_clock_in = 1'b0;
        line_data_in  = 1'b0;
        #2.3;
        forever
        begin
            if (bits_q.size() == 0)
            begin
                line_data_in = ~line_data_in; // idle line shows no stale bit
                #80;
            end
            else
            begin
                line_data_in = bits_q.pop_front();
                #80;
                line_clock_in = 1'b1;
                #80;
                line_clock_in = 1'b0;
            end
        end
    end
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic       clk;
    logic       reset_n;
    logic       req_n;
    logic       lck;
    logic       ldat;
    logic       byte_clock_out;
    logic [7:0] parallel_byte_out;
    logic       byte_valid;
    logic       frame_pulse;
    logic [7:0] got;
    logic       got_fp;
    int         mismatches;
    int         n_checks;

    // system clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    line_source src (.line_clock_in(lck), .line_data_in(ldat));

    sts_frame_byte_aligner DUT
    (
        .clk(clk), .reset_n(reset_n), .line_clock_in(lck),
        .line_data_in(ldat), .out_of_frame_request_n(req_n),
        .byte_clock_out(byte_clock_out), .parallel_byte_out(parallel_byte_out),
        .byte_valid(byte_valid), .frame_pulse(frame_pulse)
    );

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL %0t got %h want %h", $time, seen, exp);
        end
    endtask

    // next rising byte clock, bounded
    task automatic next_byte();
        logic low;
        low = 1'b0;
        for (int i = 0; i < 1200; i++)
        begin
            @(posedge clk);
            #1;
            if (low && byte_clock_out === 1'b1)
            begin
                got = parallel_byte_out;
                got_fp = frame_pulse;
                return;
            end
            low = low | (byte_clock_out === 1'b0);
        end
        mismatches++;
        $display("FAIL %0t byte clock stalled", $time);
        test_done();
    endtask

    task automatic push_frame();
        repeat (3) src.push_bits(8'hF6, 8);
        repeat (3) src.push_bits(8'h28, 8);
    endtask

    // framing without a request must give nothing
    task automatic t_unarmed();
        src.push_bits(8'h3C, 8);
        push_frame();
        for (int i = 0; i < 4; i++)
            src.push_bits(8'(8'h11 * (i + 1)), 8);
        repeat (9)
        begin
            next_byte();
            check({7'h0, got_fp}, 8'h00);
            check({7'h0, byte_valid}, 8'h00);
        end
        $display("test unarmed done");
    endtask

    // arm, lock at bit offset off, check lock byte, pulse and payload
    task automatic t_lock(input int off);
        logic [39:0] exp;
        exp = 40'h2828112233;
        src.push_bits(8'h5A, off);
        src.push_bits(8'h3C, 8);
        src.push_bits(8'hC3, 8);
        @(posedge clk);
        req_n <= 1'b0; // falls at least 5 bytes before the change
        repeat (300) @(posedge clk);
        req_n <= 1'b1; // low longer than a byte
        push_frame();
        for (int i = 0; i < 6; i++)
            src.push_bits(8'(8'h11 * (i + 1)), 8);
        #1;
        check({6'h0, byte_valid, byte_clock_out}, 8'h00);
        // sample each edge after it settles; the lock must come in time
        for (int i = 0; i < 4000 && byte_valid !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        if (byte_valid !== 1'b1)
        begin
            mismatches++;
            $display("FAIL %0t lock not reached", $time);
            test_done();
        end
        check(parallel_byte_out, 8'h28);
        check({7'h0, byte_clock_out}, 8'h01);
        for (int k = 1; k < 6; k++)
        begin
            next_byte();
            check(got, exp[47 - 8 * k -: 8]);
            check({7'h0, got_fp}, {7'h0, k == 2});
        end
        $display("test lock offset %0d done", off);
    endtask

    // pattern in payload at another phase must not move anything
    task automatic t_no_realign();
        logic seen;
        seen = 1'b0;
        src.push_bits(8'hE0, 3);
        push_frame();
        src.push_bits(8'h00, 5);
        src.push_bits(8'hC3, 8);
        repeat (3) src.push_bits(8'h81, 8);
        repeat (11)
        begin
            next_byte();
            check({7'h0, got_fp}, 8'h00);
            check({7'h0, byte_valid}, 8'h01);
            seen = seen | (got === 8'hC3);
        end
        check({7'h0, seen}, 8'h01);
        $display("test no realign done");
    endtask

    // main sequence
    initial
    begin
        mismatches = 0;
        n_checks = 0;
        reset_n = 1'b0;
        req_n = 1'b1;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        t_unarmed();
        for (int off = 0; off < 8; off++)
            t_lock(off);
        t_no_realign();
        test_done();
    end
endmodule
